// ---- hdl/cmcc_core_control.sv ----
// Functional notes
// - A 12-bit address selects one of 4096 words per access.
// - Six bits pick the Y line via upper and lower 3-bit decoders, sixteen switches.
// - Remaining six bits pick one of 64 X lines via sixteen switches.
// - Read currents enable only after X and Y selection completes.
// - Read clears the word; sense appears only where a one was stored.
// - Amplified sense bits are strobed into the 25-bit word capture register.
// - Read-restore rewrites the captured word: inhibit zeros, then write currents.
// - Clear-write stores requester data, loaded before inhibit and write currents.
// - Each word holds 24 data bits and one parity bit.
// - Read data within 1 us of start; full cycle takes 4 us.
`default_nettype none
module cmcc_core_control #(
    parameter int ACCESS_CYC = cmcc_pkg::ACCESS_CYC,
    parameter int CYCLE_CYC  = cmcc_pkg::CYCLE_CYC
) (
    input  wire logic                           clk_sys,
    input  wire logic                           rst,
    input  wire logic                           clkEn,
    input  wire logic                           reqValid,
    input  wire cmcc_pkg::cmcc_req_t            req,
    input  wire logic [cmcc_pkg::WORD_W-1:0]    senseIn,
    output logic                                reqReady,
    output logic                                dataValid,
    output logic      [cmcc_pkg::WORD_W-1:0]    rdData,
    output logic                                cycleDone,
    output cmcc_pkg::cmcc_drive_t               drive
);
    localparam int RD_CYC  = ACCESS_CYC - cmcc_pkg::SELECT_CYC - 1;
    localparam int WR_CYC  = CYCLE_CYC - ACCESS_CYC - cmcc_pkg::INHIBIT_CYC;

    if (RD_CYC < 2 || WR_CYC < 1 || CYCLE_CYC >= (1 << cmcc_pkg::CNT_W)) begin : g_bad_timing
        $error("cmcc_core_control: cycle timing cannot be served");
    end

    typedef enum logic [2:0] {
        CMCC_IDLE    = 3'b000,
        CMCC_SELECT  = 3'b001,
        CMCC_READ    = 3'b011,
        CMCC_STROBE  = 3'b010,
        CMCC_INHIBIT = 3'b110,
        CMCC_WRITE   = 3'b111,
        CMCC_DONE    = 3'b101
    } cmcc_state_t;

    cmcc_state_t                       state_q,   state_d;
    logic [cmcc_pkg::CNT_W-1:0]        cnt_q,     cnt_d;
    logic [cmcc_pkg::ADDR_W-1:0]       addr_q,    addr_d;
    cmcc_pkg::cmcc_mode_t              mode_q,    mode_d;
    logic [cmcc_pkg::WORD_W-1:0]       capture_q, capture_d;
    logic [cmcc_pkg::WORD_W-1:0]       wrHold_q,  wrHold_d;
    logic                              ready_q,   ready_d;
    logic                              valid_q,   valid_d;
    logic                              done_q,    done_d;
    cmcc_pkg::cmcc_drive_t             drive_q,   drive_d;
    logic [cmcc_pkg::LINES-1:0]        xHot,      yHot;
    logic [cmcc_pkg::SWITCHES-1:0]     xSw,       ySw;

    // Y: upper and lower decoders each take three bits
    cmcc_line_decoder #(.GRP_W(cmcc_pkg::GRP_W)) u_y_dec (
        .upperSel     (addr_q[cmcc_pkg::Y_UPPER_LSB +: cmcc_pkg::GRP_W]),
        .lowerSel     (addr_q[cmcc_pkg::Y_LOWER_LSB +: cmcc_pkg::GRP_W]),
        .lineOneHot   (yHot),
        .switchOneHot (ySw)
    );

    // X: the remaining six bits
    cmcc_line_decoder #(.GRP_W(cmcc_pkg::GRP_W)) u_x_dec (
        .upperSel     (addr_q[cmcc_pkg::X_LSB + cmcc_pkg::GRP_W +: cmcc_pkg::GRP_W]),
        .lowerSel     (addr_q[cmcc_pkg::X_LSB +: cmcc_pkg::GRP_W]),
        .lineOneHot   (xHot),
        .switchOneHot (xSw)
    );

    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        addr_d    = addr_q;
        mode_d    = mode_q;
        capture_d = capture_q;
        wrHold_d  = wrHold_q;
        ready_d   = ready_q;
        valid_d   = 1'b0;
        done_d    = 1'b0;
        drive_d   = drive_q;
        unique case (state_q)
            CMCC_IDLE: begin
                drive_d = '0;
                if (reqValid && ready_q) begin
                    // Whole address latched: one word of 4096 per access
                    addr_d   = req.addr;
                    mode_d   = req.mode;
                    wrHold_d = req.wrData;
                    ready_d  = 1'b0;
                    cnt_d    = cmcc_pkg::CNT_W'(cmcc_pkg::SELECT_CYC - 1);
                    state_d  = CMCC_SELECT;
                end
            end
            CMCC_SELECT: begin
                drive_d.xLine   = xHot;
                drive_d.yLine   = yHot;
                drive_d.xSwitch = xSw;
                drive_d.ySwitch = ySw;
                if (cnt_q == '0) begin
                    // Lines settled before any read current flows
                    drive_d.readCurrent = 1'b1;
                    // Strobe cycle closes the read phase, so data stands before ACCESS_CYC
                    cnt_d   = cmcc_pkg::CNT_W'(RD_CYC - 2);
                    state_d = CMCC_READ;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            CMCC_READ: begin
                // Read current drives all cores of the word to zero
                if (cnt_q == '0) begin
                    drive_d.readCurrent = 1'b0;
                    state_d = CMCC_STROBE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            CMCC_STROBE: begin
                // Only ones produce sense output, so the strobe is the old word
                capture_d = senseIn;
                valid_d   = 1'b1;
                cnt_d     = cmcc_pkg::CNT_W'(cmcc_pkg::INHIBIT_CYC - 1);
                state_d   = CMCC_INHIBIT;
                // Clear-write data replaces the read value before inhibit
                if (mode_q == cmcc_pkg::CMCC_CLEAR_WRITE) begin
                    drive_d.inhibit = ~wrHold_q;
                end else begin
                    drive_d.inhibit = ~senseIn;
                end
            end
            CMCC_INHIBIT: begin
                if (cnt_q == '0) begin
                    // Write currents only after inhibit is in place
                    drive_d.writeCurrent = 1'b1;
                    cnt_d   = cmcc_pkg::CNT_W'(WR_CYC - 1);
                    state_d = CMCC_WRITE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            CMCC_WRITE: begin
                if (cnt_q == '0) begin
                    drive_d = '0;
                    state_d = CMCC_DONE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            CMCC_DONE: begin
                // Cycle ends 4 us after acceptance; reopen only now
                done_d  = 1'b1;
                ready_d = 1'b1;
                state_d = CMCC_IDLE;
            end
            default: begin
                drive_d = '0;
                ready_d = 1'b1;
                state_d = CMCC_IDLE;
            end
        endcase
    end

    // Capture register is written only in the strobe state, so it holds
    // unchanged through inhibit and write
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q   <= CMCC_IDLE;
            cnt_q     <= '0;
            addr_q    <= '0;
            mode_q    <= cmcc_pkg::CMCC_READ_RESTORE;
            capture_q <= '0;
            wrHold_q  <= '0;
            ready_q   <= 1'b1;
            valid_q   <= 1'b0;
            done_q    <= 1'b0;
            drive_q   <= '0;
        end else if (clkEn) begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            addr_q    <= addr_d;
            mode_q    <= mode_d;
            capture_q <= capture_d;
            wrHold_q  <= wrHold_d;
            ready_q   <= ready_d;
            valid_q   <= valid_d;
            done_q    <= done_d;
            drive_q   <= drive_d;
        end
    end

    assign reqReady  = ready_q;
    assign dataValid = valid_q;
    assign rdData    = capture_q;
    assign cycleDone = done_q;
    assign drive     = drive_q;
endmodule : cmcc_core_control
`default_nettype wire

// ---- hdl/cmcc_line_decoder.sv ----
`default_nettype none
// One-hot line select built from two 3-bit group decoders; also names the
// read-write switch of each group pair used by the line.
module cmcc_line_decoder #(
    parameter int GRP_W = 3
) (
    input  wire logic [GRP_W-1:0]          upperSel,
    input  wire logic [GRP_W-1:0]          lowerSel,
    output logic      [(1<<(2*GRP_W))-1:0] lineOneHot,
    output logic      [(1<<(GRP_W+1))-1:0] switchOneHot
);
    localparam int N = 1 << GRP_W;

    if (GRP_W < 1 || GRP_W > 4) begin : g_bad_grp
        $error("cmcc_line_decoder: GRP_W out of range");
    end

    logic [N-1:0] upperHot;
    logic [N-1:0] lowerHot;

    genvar i, j;
    generate
        for (i = 0; i < N; i++) begin : g_grp
            assign upperHot[i] = (upperSel == GRP_W'(i));
            assign lowerHot[i] = (lowerSel == GRP_W'(i));
            // Upper group drives a source switch, lower group a sink switch
            assign switchOneHot[i]     = upperHot[i];
            assign switchOneHot[N + i] = lowerHot[i];
            for (j = 0; j < N; j++) begin : g_line
                assign lineOneHot[i*N + j] = upperHot[i] & lowerHot[j];
            end
        end
    endgenerate
endmodule : cmcc_line_decoder
`default_nettype wire

// ---- hdl/cmcc_pkg.sv ----
`default_nettype none
package cmcc_pkg;
    localparam int ADDR_W         = 12;
    localparam int WORDS          = 4096;
    localparam int DATA_W         = 24;
    localparam int WORD_W         = 25;
    localparam int SEL_W          = 6;
    localparam int LINES          = 64;
    localparam int SWITCHES       = 16;
    localparam int GRP_W          = 3;
    localparam int X_LSB          = 0;
    localparam int Y_LOWER_LSB    = 6;
    localparam int Y_UPPER_LSB    = 9;
    localparam int PARITY_BIT     = 24;
    localparam int CLK_HZ         = 20_000_000;
    localparam int ACCESS_NS      = 1000;
    localparam int CYCLE_NS       = 4000;
    // Longest times round down
    localparam int ACCESS_CYC     = (ACCESS_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int CYCLE_CYC      = (CYCLE_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int SELECT_CYC     = 2;
    localparam int READ_CYC       = ACCESS_CYC - SELECT_CYC - 1;
    localparam int INHIBIT_CYC    = 2;
    localparam int WRITE_CYC      = CYCLE_CYC - ACCESS_CYC - INHIBIT_CYC;
    localparam int CNT_W          = 8;

    typedef enum logic {
        CMCC_READ_RESTORE = 1'b0,
        CMCC_CLEAR_WRITE  = 1'b1
    } cmcc_mode_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        cmcc_mode_t        mode;
        logic [WORD_W-1:0] wrData;
    } cmcc_req_t;

    typedef struct packed {
        logic [LINES-1:0]  xLine;
        logic [LINES-1:0]  yLine;
        logic [SWITCHES-1:0] xSwitch;
        logic [SWITCHES-1:0] ySwitch;
        logic              readCurrent;
        logic              writeCurrent;
        logic [WORD_W-1:0] inhibit;
    } cmcc_drive_t;
endpackage : cmcc_pkg
`default_nettype wire

// ---- verification/cmcc_core_control_props.sv ----
`default_nettype none
module cmcc_core_control_props #(
    parameter int ACCESS_CYC = cmcc_pkg::ACCESS_CYC,
    parameter int CYCLE_CYC  = cmcc_pkg::CYCLE_CYC
) (
    input wire logic                        clk_sys,
    input wire logic                        rst,
    input wire logic                        clkEn,
    input wire logic                        reqValid,
    input wire cmcc_pkg::cmcc_req_t         req,
    input wire logic [cmcc_pkg::WORD_W-1:0] senseIn,
    input wire logic                        reqReady,
    input wire logic                        dataValid,
    input wire logic [cmcc_pkg::WORD_W-1:0] rdData,
    input wire logic                        cycleDone,
    input wire cmcc_pkg::cmcc_drive_t       drive
);
    // Outputs are seen one edge after the edge that sets them
    localparam int DV_DLY   = ACCESS_CYC;
    localparam int DONE_DLY = CYCLE_CYC + 1;
    default clocking @(posedge clk_sys); endclocking
    // A frozen cycle stretches every count, so timed attempts are dropped then
    default disable iff (rst || !clkEn);
    cmcc_pkg::cmcc_req_t held_q;
    cmcc_pkg::cmcc_req_t held_d;
    always_comb held_d = (clkEn && reqValid && reqReady) ? req : held_q;
    always_ff @(posedge clk_sys) held_q <= held_d;

    property p_busy; clkEn && reqValid && reqReady |=> !reqReady; endproperty
    a_busy: assert property (p_busy) else $error("ready after accept");
    property p_data; clkEn && reqValid && reqReady |-> ##DV_DLY dataValid; endproperty
    a_data: assert property (p_data) else $error("data late");
    property p_done;
        clkEn && reqValid && reqReady |-> ##DONE_DLY (cycleDone && reqReady);
    endproperty
    a_done: assert property (p_done) else $error("cycle end wrong");
    property p_ready; $rose(reqReady) |-> cycleDone; endproperty
    a_ready: assert property (p_ready) else $error("ready before rewrite end");
    property p_sel;
        $rose(drive.readCurrent) |-> $stable(drive.xLine) && $stable(drive.yLine)
            && drive.xLine == 64'h1 << held_q.addr[5:0]
            && drive.yLine == 64'h1 << held_q.addr[11:6];
    endproperty
    a_sel: assert property (p_sel) else $error("line select");
    property p_capture; dataValid |-> rdData == $past(senseIn); endproperty
    a_capture: assert property (p_capture) else $error("capture");
    property p_hold; !dataValid |-> $stable(rdData); endproperty
    a_hold: assert property (p_hold) else $error("capture changed");
    property p_inhibit;
        $rose(drive.writeCurrent) |-> $past(drive.inhibit, 2) == drive.inhibit
            && drive.inhibit == ~(held_q.mode == cmcc_pkg::CMCC_CLEAR_WRITE
                                  ? held_q.wrData : rdData);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit");
    property p_excl; !(drive.readCurrent && drive.writeCurrent); endproperty
    a_excl: assert property (p_excl) else $error("read and write overlap");
endmodule : cmcc_core_control_props

bind cmcc_core_control cmcc_core_control_props #(
    .ACCESS_CYC(ACCESS_CYC), .CYCLE_CYC(CYCLE_CYC)
) cmcc_core_control_props_i (
    .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .reqValid(reqValid), .req(req),
    .senseIn(senseIn), .reqReady(reqReady), .dataValid(dataValid), .rdData(rdData),
    .cycleDone(cycleDone), .drive(drive)
);
`default_nettype wire

// ---- verification/cmcc_core_stack.sv ----
`default_nettype none
module cmcc_core_stack (
    input  wire logic                   clk_sys,
    input  wire cmcc_pkg::cmcc_drive_t  drive,
    output logic [cmcc_pkg::WORD_W-1:0] senseIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [cmcc_pkg::WORD_W-1:0] cores [cmcc_pkg::WORDS];
    logic                        sensed;
    logic                        written;
    int                          idx;
    function automatic int cmcc_hot(input logic [63:0] v);
        for (int i = 0; i < 64; i++)
            if (v[i]) return i;
        return 0;
    endfunction : cmcc_hot
    initial begin
        foreach (cores[i]) cores[i] = '0;
        {sensed, written, senseIn} = '0;
    end
    assign idx = cmcc_hot(drive.yLine) * 64 + cmcc_hot(drive.xLine);
    always @(posedge clk_sys) begin
        if (drive.xLine == '0) {sensed, written} <= '0;
        if (drive.readCurrent && !sensed) begin
            senseIn <= cores[idx]; // Ones show, every core ends at zero
            cores[idx] <= '0;
            sensed <= 1'b1;
        end
        if (drive.writeCurrent && !written) begin
            cores[idx] <= ~drive.inhibit; // Inhibited bits stay zero
            senseIn <= ~senseIn; // Sense lines flip to the complement of the read word once writing starts
            written <= 1'b1;
        end
    end
endmodule : cmcc_core_stack
`default_nettype wire

// ---- verification/core_memory_cycle_control_test.sv ----
`default_nettype none
module core_memory_cycle_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int W = cmcc_pkg::WORD_W;
    logic                  clk_sys = 1'b0;
    logic                  rst = 1'b1;
    logic                  clkEn = 1'b1;
    logic                  reqValid = 1'b0;
    cmcc_pkg::cmcc_req_t   req = '0;
    logic [W-1:0]          senseIn, rdData, got;
    logic                  reqReady, dataValid, cycleDone;
    cmcc_pkg::cmcc_drive_t drive;
    int                    mismatches = 0;
    int                    comparisons = 0;
    always #25 clk_sys = ~clk_sys;
    cmcc_core_control cmcc_core_control_i (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn),
        .reqValid(reqValid), .req(req), .senseIn(senseIn), .reqReady(reqReady),
        .dataValid(dataValid), .rdData(rdData), .cycleDone(cycleDone), .drive(drive));
    cmcc_core_stack cmcc_core_stack_i (.clk_sys(clk_sys), .drive(drive), .senseIn(senseIn));

    task automatic check_word(input logic [W-1:0] act, input logic [W-1:0] exp);
        comparisons++;
        if (act !== exp) begin
            mismatches++;
            $display("MISMATCH %0t word %h expected %h", $time, act, exp);
        end
    endtask : check_word
    task automatic check_count(input int act, input int exp);
        comparisons++;
        if (act != exp) begin
            mismatches++;
            $display("MISMATCH %0t cycles %0d expected %0d", $time, act, exp);
        end
    endtask : check_count
    // With pester set, a conflicting request is held up all through the cycle;
    // stall freezes the block for that many cycles from the fifth cycle on
    task automatic access(input logic [11:0] a, input cmcc_pkg::cmcc_mode_t m,
                          input logic [W-1:0] w, input logic pester, input int stall);
        int n;
        n = 0;
        while (reqReady !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        req = '{addr: a, mode: m, wrData: w};
        reqValid = 1'b1;
        @(posedge clk_sys);
        #1;
        reqValid = pester;
        req = '{addr: 12'h555, mode: cmcc_pkg::CMCC_CLEAR_WRITE, wrData: '1};
        n = 0;
        while (cycleDone !== 1'b1 && n < 200) begin
            if (dataValid === 1'b1) begin
                got = rdData;
                check_count(n, cmcc_pkg::ACCESS_CYC - 1 + stall);
            end
            @(posedge clk_sys);
            #1;
            n++;
            clkEn = (n < 5 || n >= 5 + stall);
        end
        reqValid = 1'b0;
        check_count(n, cmcc_pkg::CYCLE_CYC + stall);
        // One idle cycle keeps the next request off the step that lowered this one
        @(posedge clk_sys);
        #1;
    endtask : access
    task automatic t_write_read();
        logic [11:0]  a [3] = '{12'h000, 12'hfff, 12'h9c6};
        logic [W-1:0] w [3] = '{25'h1000001, 25'h0ffffff, 25'h1a5c3e7};
        for (int i = 0; i < 3; i++) begin
            access(a[i], cmcc_pkg::CMCC_CLEAR_WRITE, w[i], 1'b0, 0);
            check_word(got, '0);
        end
        for (int r = 0; r < 6; r++) begin
            access(a[r % 3], cmcc_pkg::CMCC_READ_RESTORE, '0, 1'b0, 0);
            check_word(got, w[r % 3]);
        end
        $display("t_write_read done");
    endtask : t_write_read
    task automatic t_refuse();
        access(12'h2a4, cmcc_pkg::CMCC_CLEAR_WRITE, 25'h0123456, 1'b1, 0);
        access(12'h555, cmcc_pkg::CMCC_READ_RESTORE, '0, 1'b0, 0);
        check_word(got, '0);
        access(12'h2a4, cmcc_pkg::CMCC_READ_RESTORE, '0, 1'b0, 0);
        check_word(got, 25'h0123456);
        $display("t_refuse done");
    endtask : t_refuse
    // A frozen read-restore must still capture and rewrite the stored word
    task automatic t_stall();
        access(12'h9c6, cmcc_pkg::CMCC_READ_RESTORE, '0, 1'b0, 4);
        check_word(got, 25'h1a5c3e7);
        access(12'h9c6, cmcc_pkg::CMCC_READ_RESTORE, '0, 1'b0, 0);
        check_word(got, 25'h1a5c3e7);
        $display("t_stall done");
    endtask : t_stall
    task automatic print_verdict();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    initial begin
        #400_000;
        mismatches++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        t_write_read();
        t_refuse();
        t_stall();
        print_verdict();
    end
endmodule : core_memory_cycle_control_test
`default_nettype wire
